// File: test/display_video_timing_generator_test.sv
`timescale 1ns/1ps
module display_video_timing_generator_test;
  import video_timing_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  wb_req_t req = '0;
  engine_write_t eng = '0;
  video_out_t vid;
  logic [31:0] rdat, d, s0;
  logic [31:0] seed = 32'h00001769;
  logic ack;
  logic [19:0] step = 20'h00000;
  logic [19:0] first_addr;
  logic dbl = 1'b0;
  int fails, n_compared, frames, cyc_n, hs_n, vs_n, bl_n, dat_n, bad_n, b0;
  int tv[9] = '{15, 9, 3, 5, 7, 9, 2, 4, 5};
  int hs_e[4] = '{160, 20, 0, 140};
  always #12.5 clk = ~clk;
  display_video_timing_generator u_dut (.clk(clk), .rst_b(rst_b), .wb_req(req), .wb_dat_o(rdat),
    .wb_ack_o(ack), .eng_wr(eng), .video(vid));
  video_sink u_sink (.clk(clk), .video(vid), .step(step), .dbl(dbl), .frames(frames), .cyc_n(cyc_n),
    .hs_n(hs_n), .vs_n(vs_n), .bl_n(bl_n), .dat_n(dat_n), .bad_n(bad_n), .first_addr(first_addr));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] v);
    int n;
    req <= '{1'b1, 1'b1, w, 4'hF, a, v};
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    d = rdat;
    req <= '0;
    if (ack !== 1'b1)
    begin
      fails++;
      stop_test();
    end
    @(posedge clk);
  endtask : bus
  task automatic rd(input logic [15:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, DATA_ZERO);
    chk(nm, e, d);
  endtask : rd
  task automatic fw(input int k);
    int t, n;
    t = frames + k;
    n = 0;
    while (frames < t && n < 40000 * k)
    begin
      @(posedge clk);
      n++;
    end
    if (frames < t)
    begin
      fails++;
      stop_test();
    end
  endtask : fw
  task automatic run(input logic [31:0] c, input logic db, input int fc, input int h, input int b, input int x);
    bus(1'b1, ADDR_CONTROL, c);
    dbl <= db;
    fw(2);
    b0 = bad_n;
    fw(1);
    chk("frame cycles", fc, cyc_n);
    chk("hsync cycles", h, hs_n);
    chk("blank cycles", b, bl_n);
    chk("data units", x, dat_n);
    chk("vsync cycles", 16 * fc / 160, vs_n);
    chk("line steps", b0, bad_n);
    chk("unit width", 32'(c[16]), 32'(vid.wide));
  endtask : run
  initial
  begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 12; i++)
      rd(ADDR_START + 16'(8 * i), DATA_ZERO, "reset value");
    for (int i = 1; i < 12; i++)
    begin
      seed = lfsr(seed);
      bus(1'b1, ADDR_START + 16'(8 * i), seed);
      rd(ADDR_START + 16'(8 * i), seed & (i == 1 ? 32'h000FFFFF : i == 11 ? 32'h0001FE7F : 32'h000007FF),
        "readback");
    end
    bus(1'b1, 16'h3060, seed);
    rd(16'h3060, DATA_ZERO, "unmapped");
    for (int i = 0; i < 9; i++)
      bus(1'b1, ADDR_HTOTAL + 16'(8 * i), 32'(tv[i]));
    step <= seed[19:0];
    bus(1'b1, ADDR_PITCH, seed);
    seed = lfsr(seed);
    s0 = seed & 32'h000FFFFF;
    bus(1'b1, ADDR_START, seed);
    bus(1'b1, ADDR_CONTROL, 32'h00000029);
    fw(2);
    run(32'h00000029, 1'b0, 160, 20, 64, 48);
    chk("first address", s0, 32'(first_addr));
    for (int m = 0; m < 4; m++)
      run(32'h00000021 | (m << 3) | ((m & 1) << 1), 1'b0, 160, hs_e[m], (m & 1) ? 96 : 64, 48);
    run(32'h0000002D, 1'b1, 320, 40, 128, 96);
    run(32'h00010029, 1'b0, 160, 20, 64, 48);
    seed = lfsr(seed);
    bus(1'b1, ADDR_START, seed);
    rd(ADDR_CONTROL, 32'h000100A9, "host pending");
    fw(1);
    rd(ADDR_CONTROL, 32'h00010029, "host consumed");
    chk("first address", seed & 32'h000FFFFF, 32'(first_addr));
    chk("line steps", b0, bad_n);
    seed = lfsr(seed);
    eng <= '{1'b1, seed[19:0]};
    @(posedge clk);
    eng <= '0;
    @(posedge clk);
    rd(ADDR_CONTROL, 32'h00010129, "engine pending");
    fw(1);
    rd(ADDR_CONTROL, 32'h00010029, "engine consumed");
    chk("first address", seed & 32'h000FFFFF, 32'(first_addr));
    bus(1'b1, ADDR_CONTROL, 32'h00000229);
    bus(1'b1, ADDR_START, seed);
    rd(ADDR_CONTROL, 32'h00000229, "swap immediate");
    stop_test();
  end
endmodule : display_video_timing_generator_test

// File: test/video_sink.sv
`timescale 1ns/1ps
module video_sink (
  // clock
  input wire logic clk,
  // monitor and pixel path
  input wire video_timing_pkg::video_out_t video,
  // expected line step and repeat mode
  input wire logic [19:0] step,
  input wire logic dbl,
  // results of the last whole frame, plus running counts of frames and line-step errors
  output int frames,
  output int cyc_n,
  output int hs_n,
  output int vs_n,
  output int bl_n,
  output int dat_n,
  output int bad_n,
  output logic [19:0] first_addr
);
  int c_cyc, c_hs, c_vs, c_bl, c_dat, gap;
  logic vs_d = 1'b1;
  logic ph = 1'b0;
  logic rise;
  logic [19:0] prev;
  assign rise = video.vsync && !vs_d;
  always @(posedge clk)
  begin
    vs_d <= video.vsync;
    c_cyc <= rise ? 1 : c_cyc + 1;
    c_hs <= (rise ? 0 : c_hs) + int'(video.hsync);
    c_vs <= (rise ? 0 : c_vs) + int'(video.vsync);
    c_bl <= (rise ? 0 : c_bl) + int'(video.blank);
    c_dat <= (rise ? 0 : c_dat) + int'(video.data_clk);
    if (rise)
    begin
      frames <= frames + 1;
      cyc_n <= c_cyc;
      hs_n <= c_hs;
      vs_n <= c_vs;
      bl_n <= c_bl;
      dat_n <= c_dat;
    end
    if (video.data_clk)
    begin
      gap <= 0;
      if (gap > 20)
      begin
        first_addr <= video.line_addr;
        ph <= dbl;
      end
      else if (gap > 0)
      begin
        if (video.line_addr !== prev + (ph ? 20'h00000 : step))
          bad_n <= bad_n + 1;
        ph <= dbl && !ph;
      end
      prev <= video.line_addr;
    end
    else
      gap <= gap + 1;
  end
endmodule : video_sink

// File: test/video_timing_checker.sv
`timescale 1ns/1ps
module video_timing_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // bus and engine
  input wire video_timing_pkg::wb_req_t wb_req,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire video_timing_pkg::engine_write_t eng_wr,
  // video side
  input wire video_timing_pkg::video_out_t video
);
  import video_timing_pkg::*;
  logic [31:0] ctl_reg;
  logic [31:0] mask;
  logic [1:0] age_reg;
  logic rd_ack;
  assign mask = {{8{wb_req.sel[3]}}, {8{wb_req.sel[2]}}, {8{wb_req.sel[1]}}, {8{wb_req.sel[0]}}};
  assign rd_ack = wb_ack_o && !wb_req.we;
  // control word as the bus wrote it
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      ctl_reg <= DATA_ZERO;
    else if (wb_ack_o && wb_req.we && wb_req.adr == ADDR_CONTROL)
      ctl_reg <= (ctl_reg & ~mask) | (wb_req.dat & mask);
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      age_reg <= 2'h0;
    else if (age_reg != 2'h3)
      age_reg <= age_reg + 2'h1;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_take;
    wb_req.cyc && wb_req.stb && !wb_ack_o;
  endsequence
  sequence s_settled;
    age_reg == 2'h3 && $stable(ctl_reg);
  endsequence
  property p_take_ack;
    s_take |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_take_ack: assert property (p_take_ack) else $error("bus ack late or long");
  property p_idle_zero;
    !wb_ack_o |-> wb_dat_o == DATA_ZERO;
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("read data outside ack");
  property p_addr_hi;
    rd_ack && (wb_req.adr == ADDR_START || wb_req.adr == ADDR_PITCH) |-> wb_dat_o[31:20] == 12'h000;
  endproperty
  a_addr_hi: assert property (p_addr_hi) else $error("address field upper bits set");
  property p_count_hi;
    rd_ack && wb_req.adr >= ADDR_HTOTAL && wb_req.adr <= ADDR_VSYNC_LAST |-> wb_dat_o[31:11] == 21'h000000;
  endproperty
  a_count_hi: assert property (p_count_hi) else $error("count field upper bits set");
  property p_ctl_hi;
    rd_ack && wb_req.adr == ADDR_CONTROL |-> wb_dat_o[31:17] == 15'h0000;
  endproperty
  a_ctl_hi: assert property (p_ctl_hi) else $error("control upper bits set");
  property p_hsync_forced;
    s_settled ##0 !ctl_reg[3] |-> video.hsync == !ctl_reg[4];
  endproperty
  a_hsync_forced: assert property (p_hsync_forced) else $error("hsync not at forced level");
  property p_vsync_forced;
    s_settled ##0 !ctl_reg[5] |-> video.vsync == !ctl_reg[6];
  endproperty
  a_vsync_forced: assert property (p_vsync_forced) else $error("vsync not at forced level");
  property p_wide;
    s_settled |-> video.wide == ctl_reg[16];
  endproperty
  a_wide: assert property (p_wide) else $error("unit width differs from control");
  property p_no_data;
    s_settled ##0 !ctl_reg[0] |-> !video.data_clk;
  endproperty
  a_no_data: assert property (p_no_data) else $error("data clocked while disabled");
endmodule : video_timing_checker
bind display_video_timing_generator video_timing_checker u_chk (.clk(clk), .rst_b(rst_b), .wb_req(wb_req),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .eng_wr(eng_wr), .video(video));

// File: verilog/display_video_timing_generator.sv
`timescale 1ns/1ps
// Function
// - start address bits 0-19, top-left pixel address in 64-bit units
// - new start address takes effect at the next vertical blank, or at once when control bits 9-10 select immediate swap
// - pending flag stays set until the new start address is consumed
// - control bit 7 read-only, set by bus write of start address
// - control bit 8 read-only, set by engine write of start address
// - line pitch bits 0-19, distance between displayed lines, 64-bit units
// - horizontal total bits 0-10, index of last unit of a line
// - gate end bits 0-10, index of last unit of gate interval
// - no video data clocked out during the horizontal gate interval
// - new gate end takes effect only at the next vertical blank
// - horizontal blank end bits 0-10, last unit of blanking
// - horizontal sync start bits 0-10, first unit in sync
// - horizontal sync end bits 0-10, first unit after sync
// - vertical total bits 0-10, index of last scanline of frame
// - vertical blank end bits 0-10, first line after blanking
// - vertical sync start bits 0-10, line before sync begins
// - vertical sync end bits 0-10, last line within sync
// - control bit 2 set outputs each scanline twice, else once
// - control bit 16 selects 64-bit units to dac, else 32-bit
module display_video_timing_generator (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // wishbone slave
  input wire video_timing_pkg::wb_req_t wb_req,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // graphics engine start address path
  input wire video_timing_pkg::engine_write_t eng_wr,
  // monitor and pixel path
  output video_timing_pkg::video_out_t video
);
  import video_timing_pkg::*;

  // byte-lane merge for partial writes
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
        r[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return r;
  endfunction : lane_merge

  // drive a sync line from its mode and its active level
  function automatic logic sync_drive(input logic [1:0] mode, input logic act);
    case (sync_mode_t'(mode))
      SYNC_FORCE_HIGH: return 1'b1;
      SYNC_ACTIVE_HIGH: return act;
      SYNC_FORCE_LOW: return 1'b0;
      default: return ~act;
    endcase
  endfunction : sync_drive

  logic [ADDR_W-1:0] start_shadow_reg;
  logic [ADDR_W-1:0] start_active_reg;
  logic [ADDR_W-1:0] pitch_reg;
  logic [CNT_W-1:0] htotal_reg;
  logic [CNT_W-1:0] gate_shadow_reg;
  logic [CNT_W-1:0] gate_active_reg;
  logic [CNT_W-1:0] hblank_reg;
  logic [CNT_W-1:0] hsync_first_reg;
  logic [CNT_W-1:0] hsync_after_reg;
  logic [CNT_W-1:0] vtotal_reg;
  logic [CNT_W-1:0] vblank_reg;
  logic [CNT_W-1:0] vsync_pre_reg;
  logic [CNT_W-1:0] vsync_last_reg;
  logic [CTRL_W-1:0] ctrl_reg;
  logic pend_host_reg;
  logic pend_eng_reg;
  logic [CNT_W-1:0] hcnt_reg;
  logic [CNT_W-1:0] vcnt_reg;
  logic repeat_reg;
  logic [ADDR_W-1:0] line_addr_reg;

  logic access;
  logic wr_edge;
  logic [31:0] rd_next;
  logic [31:0] ctrl_view;
  logic [31:0] wdat;
  logic wr_start;
  logic line_end;
  logic line_advance;
  logic frame_end;
  logic swap_now;
  logic h_blank;
  logic h_sync;
  logic v_blank;
  logic v_sync;
  logic gate;

  assign access = wb_req.cyc & wb_req.stb;
  // write lands on the edge where ack is sampled high
  assign wr_edge = access & wb_req.we & wb_ack_o;
  assign wr_start = wr_edge && (wb_req.adr == ADDR_START);

  // read view of display control with live pending flags
  always_comb
  begin
    ctrl_view = {15'h0000, ctrl_reg};
    ctrl_view[CTL_PEND_HOST] = pend_host_reg;
    ctrl_view[CTL_PEND_ENG] = pend_eng_reg;
  end

  // write data merged with the current register value
  always_comb
  begin
    wdat = DATA_ZERO;
    if (wb_req.adr == ADDR_START)
      wdat = lane_merge({12'h000, start_shadow_reg}, wb_req.dat, wb_req.sel);
    else if (wb_req.adr == ADDR_PITCH)
      wdat = lane_merge({12'h000, pitch_reg}, wb_req.dat, wb_req.sel);
    else if (wb_req.adr == ADDR_HTOTAL)
      wdat = lane_merge({21'h000000, htotal_reg}, wb_req.dat, wb_req.sel);
    else if (wb_req.adr == ADDR_GATE)
      wdat = lane_merge({21'h000000, gate_shadow_reg}, wb_req.dat, wb_req.sel);
    else if (wb_req.adr == ADDR_HBLANK)
      wdat = lane_merge({21'h000000, hblank_reg}, wb_req.dat, wb_req.sel);
    else if (wb_req.adr == ADDR_HSYNC_FIRST)
      wdat = lane_merge({21'h000000, hsync_first_reg}, wb_req.dat, wb_req.sel);
    else if (wb_req.adr == ADDR_HSYNC_AFTER)
      wdat = lane_merge({21'h000000, hsync_after_reg}, wb_req.dat, wb_req.sel);
    else if (wb_req.adr == ADDR_VTOTAL)
      wdat = lane_merge({21'h000000, vtotal_reg}, wb_req.dat, wb_req.sel);
    else if (wb_req.adr == ADDR_VBLANK)
      wdat = lane_merge({21'h000000, vblank_reg}, wb_req.dat, wb_req.sel);
    else if (wb_req.adr == ADDR_VSYNC_PRE)
      wdat = lane_merge({21'h000000, vsync_pre_reg}, wb_req.dat, wb_req.sel);
    else if (wb_req.adr == ADDR_VSYNC_LAST)
      wdat = lane_merge({21'h000000, vsync_last_reg}, wb_req.dat, wb_req.sel);
    else if (wb_req.adr == ADDR_CONTROL)
      wdat = lane_merge(ctrl_view, wb_req.dat, wb_req.sel);
  end

  // read decode, unmapped reads as zero
  always_comb
  begin
    rd_next = DATA_ZERO;
    if (wb_req.adr == ADDR_START)
      rd_next = {12'h000, start_shadow_reg};
    else if (wb_req.adr == ADDR_PITCH)
      rd_next = {12'h000, pitch_reg};
    else if (wb_req.adr == ADDR_HTOTAL)
      rd_next = {21'h000000, htotal_reg};
    else if (wb_req.adr == ADDR_GATE)
      rd_next = {21'h000000, gate_shadow_reg};
    else if (wb_req.adr == ADDR_HBLANK)
      rd_next = {21'h000000, hblank_reg};
    else if (wb_req.adr == ADDR_HSYNC_FIRST)
      rd_next = {21'h000000, hsync_first_reg};
    else if (wb_req.adr == ADDR_HSYNC_AFTER)
      rd_next = {21'h000000, hsync_after_reg};
    else if (wb_req.adr == ADDR_VTOTAL)
      rd_next = {21'h000000, vtotal_reg};
    else if (wb_req.adr == ADDR_VBLANK)
      rd_next = {21'h000000, vblank_reg};
    else if (wb_req.adr == ADDR_VSYNC_PRE)
      rd_next = {21'h000000, vsync_pre_reg};
    else if (wb_req.adr == ADDR_VSYNC_LAST)
      rd_next = {21'h000000, vsync_last_reg};
    else if (wb_req.adr == ADDR_CONTROL)
      rd_next = ctrl_view;
  end

  // bus answer: ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= DATA_ZERO;
    end
    else
    begin
      wb_ack_o <= access & ~wb_ack_o;
      wb_dat_o <= (access & ~wb_ack_o & ~wb_req.we) ? rd_next : DATA_ZERO;
    end
  end

  // timing registers, one process each, written on the ack edge
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      pitch_reg <= ADDR_RESET;
    else if (wr_edge && (wb_req.adr == ADDR_PITCH))
      pitch_reg <= wdat[ADDR_W-1:0];
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      htotal_reg <= CNT_RESET;
    else if (wr_edge && (wb_req.adr == ADDR_HTOTAL))
      htotal_reg <= wdat[CNT_W-1:0];
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      gate_shadow_reg <= CNT_RESET;
    else if (wr_edge && (wb_req.adr == ADDR_GATE))
      gate_shadow_reg <= wdat[CNT_W-1:0];
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      hblank_reg <= CNT_RESET;
    else if (wr_edge && (wb_req.adr == ADDR_HBLANK))
      hblank_reg <= wdat[CNT_W-1:0];
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      hsync_first_reg <= CNT_RESET;
    else if (wr_edge && (wb_req.adr == ADDR_HSYNC_FIRST))
      hsync_first_reg <= wdat[CNT_W-1:0];
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      hsync_after_reg <= CNT_RESET;
    else if (wr_edge && (wb_req.adr == ADDR_HSYNC_AFTER))
      hsync_after_reg <= wdat[CNT_W-1:0];
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      vtotal_reg <= CNT_RESET;
    else if (wr_edge && (wb_req.adr == ADDR_VTOTAL))
      vtotal_reg <= wdat[CNT_W-1:0];
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      vblank_reg <= CNT_RESET;
    else if (wr_edge && (wb_req.adr == ADDR_VBLANK))
      vblank_reg <= wdat[CNT_W-1:0];
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      vsync_pre_reg <= CNT_RESET;
    else if (wr_edge && (wb_req.adr == ADDR_VSYNC_PRE))
      vsync_pre_reg <= wdat[CNT_W-1:0];
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      vsync_last_reg <= CNT_RESET;
    else if (wr_edge && (wb_req.adr == ADDR_VSYNC_LAST))
      vsync_last_reg <= wdat[CNT_W-1:0];
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      ctrl_reg <= CTRL_RESET;
    else if (wr_edge && (wb_req.adr == ADDR_CONTROL))
      ctrl_reg <= wdat[CTRL_W-1:0];
  end

  // raster counters
  assign line_end = (hcnt_reg == htotal_reg);
  assign line_advance = line_end & (~ctrl_reg[CTL_REPEAT] | repeat_reg);
  assign frame_end = line_advance & (vcnt_reg == vtotal_reg);

  // unit counter within a line
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      hcnt_reg <= CNT_RESET;
    else
      hcnt_reg <= line_end ? CNT_RESET : hcnt_reg + CNT_ONE;
  end

  // repeat phase: high on the second copy of a doubled line
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      repeat_reg <= 1'b0;
    else if (line_end)
      repeat_reg <= ctrl_reg[CTL_REPEAT] & ~repeat_reg;
  end

  // scanline counter within a frame
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      vcnt_reg <= CNT_RESET;
    else if (frame_end)
      vcnt_reg <= CNT_RESET;
    else if (line_advance)
      vcnt_reg <= vcnt_reg + CNT_ONE;
  end

  // start address swap: frame blank or immediate
  assign swap_now = (pend_host_reg | pend_eng_reg) &
    ((swap_policy_t'(ctrl_reg[CTL_SWAP_LO +: 2]) == SWAP_IMMEDIATE) | frame_end);

  // shadow start address, bus write wins over the engine
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      start_shadow_reg <= ADDR_RESET;
    else if (wr_start)
      start_shadow_reg <= wdat[ADDR_W-1:0];
    else if (eng_wr.we)
      start_shadow_reg <= eng_wr.addr;
  end

  // active start address only moves on a swap
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      start_active_reg <= ADDR_RESET;
    else if (swap_now)
      start_active_reg <= start_shadow_reg;
  end

  // pending flags: a new write in the swap cycle keeps its flag set
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      pend_host_reg <= 1'b0;
    else
      pend_host_reg <= wr_start | (pend_host_reg & ~swap_now);
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      pend_eng_reg <= 1'b0;
    else
      pend_eng_reg <= (eng_wr.we & ~wr_start) | (pend_eng_reg & ~swap_now);
  end

  // gate end is only taken up at frame blank
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      gate_active_reg <= CNT_RESET;
    else if (frame_end)
      gate_active_reg <= gate_shadow_reg;
  end

  // raster decode
  assign h_blank = (hcnt_reg <= hblank_reg);
  assign h_sync = (hcnt_reg >= hsync_first_reg) & (hcnt_reg < hsync_after_reg);
  assign v_blank = (vcnt_reg < vblank_reg);
  assign v_sync = (vcnt_reg > vsync_pre_reg) & (vcnt_reg <= vsync_last_reg);
  assign gate = (hcnt_reg <= gate_active_reg);

  // scanline memory address, restarted each frame
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      line_addr_reg <= ADDR_RESET;
    else if (frame_end | (line_advance & (vcnt_reg < vblank_reg)))
      line_addr_reg <= swap_now ? start_shadow_reg : start_active_reg;
    else if (line_advance)
      line_addr_reg <= line_addr_reg + pitch_reg;
  end

  // registered outputs
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      video <= '0;
    else
    begin
      video.blank <= (h_blank | v_blank) ^ ctrl_reg[CTL_BLANK_POL];
      video.hsync <= sync_drive(ctrl_reg[CTL_HSYNC_LO +: 2], h_sync);
      video.vsync <= sync_drive(ctrl_reg[CTL_VSYNC_LO +: 2], v_sync);
      video.data_clk <= ctrl_reg[CTL_ENABLE] & ~gate & ~v_blank;
      video.wide <= ctrl_reg[CTL_WIDE];
      video.line_addr <= line_addr_reg;
    end
  end

endmodule : display_video_timing_generator

// File: verilog/video_timing_pkg.sv
package video_timing_pkg;

  // register byte addresses
  localparam logic [15:0] ADDR_START = 16'h3000;
  localparam logic [15:0] ADDR_PITCH = 16'h3008;
  localparam logic [15:0] ADDR_HTOTAL = 16'h3010;
  localparam logic [15:0] ADDR_GATE = 16'h3018;
  localparam logic [15:0] ADDR_HBLANK = 16'h3020;
  localparam logic [15:0] ADDR_HSYNC_FIRST = 16'h3028;
  localparam logic [15:0] ADDR_HSYNC_AFTER = 16'h3030;
  localparam logic [15:0] ADDR_VTOTAL = 16'h3038;
  localparam logic [15:0] ADDR_VBLANK = 16'h3040;
  localparam logic [15:0] ADDR_VSYNC_PRE = 16'h3048;
  localparam logic [15:0] ADDR_VSYNC_LAST = 16'h3050;
  localparam logic [15:0] ADDR_CONTROL = 16'h3058;

  // field widths
  localparam int ADDR_W = 20;
  localparam int CNT_W = 11;
  localparam int CTRL_W = 17;

  // display control field positions
  localparam int CTL_ENABLE = 0;
  localparam int CTL_BLANK_POL = 1;
  localparam int CTL_REPEAT = 2;
  localparam int CTL_HSYNC_LO = 3;
  localparam int CTL_VSYNC_LO = 5;
  localparam int CTL_PEND_HOST = 7;
  localparam int CTL_PEND_ENG = 8;
  localparam int CTL_SWAP_LO = 9;
  localparam int CTL_WIDE = 16;

  // reset values
  localparam logic [ADDR_W-1:0] ADDR_RESET = 20'h00000;
  localparam logic [CNT_W-1:0] CNT_RESET = 11'h000;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 17'h00000;
  localparam logic [31:0] DATA_ZERO = 32'h00000000;
  localparam logic [CNT_W-1:0] CNT_ONE = 11'h001;
  localparam logic [ADDR_W-1:0] ADDR_ONE_UNIT = 20'h00000;

  // sync drive modes
  typedef enum logic [1:0] {
    SYNC_FORCE_HIGH = 2'h0,
    SYNC_ACTIVE_HIGH = 2'h1,
    SYNC_FORCE_LOW = 2'h2,
    SYNC_ACTIVE_LOW = 2'h3
  } sync_mode_t;

  // start address swap policy
  typedef enum logic [1:0] {
    SWAP_AT_BLANK = 2'h0,
    SWAP_IMMEDIATE = 2'h1
  } swap_policy_t;

  // wishbone request
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [15:0] adr;
    logic [31:0] dat;
  } wb_req_t;

  // graphics engine start address write
  typedef struct packed {
    logic we;
    logic [ADDR_W-1:0] addr;
  } engine_write_t;

  // monitor and pixel path outputs
  typedef struct packed {
    logic blank;
    logic hsync;
    logic vsync;
    logic data_clk;
    logic wide;
    logic [ADDR_W-1:0] line_addr;
  } video_out_t;

endpackage : video_timing_pkg
